// [rtl/mdio_mgr_pkg.sv]
// Shared constants, types and frame helpers for the MDIO station manager.
// Assumes a 20 MHz register clock and a 48 ns link clock.
package mdio_mgr_pkg;

  // ------------------------------------------------------------
  // Register map (APB byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STAT_OFS   = 8'h04;
  localparam logic [7:0] FRM_BASE   = 8'h40;
  localparam logic [7:0] RES_BASE   = 8'h80;
  localparam logic [3:0] MAX_FRAMES = 4'hf;

  // Control and status field positions
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_CHAN_BIT  = 1;
  localparam int CTRL_OPT_BIT   = 2;
  localparam int CTRL_CNT_LSB   = 4;
  localparam int FRM_W          = 29;

  // Values after reset
  localparam logic [3:0] CNT_RST  = 4'h0;
  localparam logic       CHAN_RST = 1'b0;
  localparam logic       OPT_RST  = 1'b0;

  // ------------------------------------------------------------
  // Link timing: half periods of the management clock
  // ------------------------------------------------------------
  localparam int LINK_NS     = 48;
  localparam int STD_HALF_NS = 200;
  localparam int OPT_HALF_NS = 125;
  localparam logic [2:0] STD_HALF_CYC =
    3'((STD_HALF_NS + LINK_NS - 1) / LINK_NS);
  localparam logic [2:0] OPT_HALF_CYC =
    3'((OPT_HALF_NS + LINK_NS - 1) / LINK_NS);

  // Bit positions inside one 64-bit frame
  localparam logic [5:0]  ST_BIT   = 6'h20;
  localparam logic [5:0]  TA_BIT   = 6'h2e;
  localparam logic [5:0]  DATA_BIT = 6'h30;
  localparam logic [5:0]  LAST_BIT = 6'h3f;
  localparam logic [31:0] PREAMBLE = 32'hffff_ffff;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    legacy_read_op         = 3'h0,
    legacy_write_op        = 3'h1,
    extended_address_op    = 3'h2,
    extended_write_op      = 3'h3,
    extended_read_op       = 3'h4,
    post_read_increment_op = 3'h5
  } mdio_op_t;

  typedef struct packed {
    mdio_op_t    op;
    logic [4:0]  port_addr;
    logic [4:0]  reg_addr;
    logic [15:0] data;
  } frame_t;

  typedef struct packed {
    logic mdc;
    logic mdo;
    logic oe;
  } mdio_pins_t;

  // Address and write frames drive turnaround; all others read
  function automatic logic is_read(mdio_op_t op);
    return !(op inside {legacy_write_op, extended_write_op,
                        extended_address_op});
  endfunction : is_read

  function automatic logic is_legacy(mdio_op_t op);
    return op inside {legacy_read_op, legacy_write_op};
  endfunction : is_legacy

  // Whole frame, first bit in bit 63
  function automatic logic [63:0] frame_bits(frame_t f);
    logic [3:0] so;
    logic [1:0] ta;
    case (f.op)
      legacy_write_op:        so = 4'h5;
      extended_address_op:    so = 4'h0;
      extended_write_op:      so = 4'h1;
      extended_read_op:       so = 4'h3;
      post_read_increment_op: so = 4'h2;
      default:                so = 4'h6;
    endcase
    ta = is_read(f.op) ? 2'h0 : 2'h2;
    return {PREAMBLE, so, f.port_addr, f.reg_addr, ta,
            is_read(f.op) ? 16'h0 : f.data};
  endfunction : frame_bits

endpackage : mdio_mgr_pkg

// [rtl/mdio_frame_engine.sv]
// One management frame, bit by bit, on the link clock.
// Assumes start_i only while idle and a pre-synchronised data input.
`timescale 1ns/1ps

module mdio_frame_engine
  import mdio_mgr_pkg::*;
(
  input  wire logic        link_clk_i,
  input  wire logic        reset_i,
  input  wire logic        start_i,
  input  wire frame_t      frame_i,
  input  wire logic        chan_i,
  input  wire logic        opt_i,
  input  wire logic        mdi_i,
  output mdio_pins_t       pins0_o,
  output mdio_pins_t       pins1_o,
  output logic             done_o,
  output logic [15:0]      rdata_o
);

  typedef enum logic {ENG_IDLE = 1'b0, ENG_RUN = 1'b1} eng_state_t;

  eng_state_t  st_r;
  frame_t      f_r;
  logic [63:0] sh_r;
  logic [5:0]  bit_r;
  logic [2:0]  hc_r;
  logic        hi_r;
  logic        rd_r;
  logic        chan_r;
  logic        opt_r;
  mdio_pins_t  pin_r;
  mdio_pins_t  pin_nxt;

  // ------------------------------------------------------------
  // Bit timing
  // ------------------------------------------------------------
  wire [2:0] half_w = opt_r ? OPT_HALF_CYC : STD_HALF_CYC;
  wire       last_w = (hc_r == half_w - 3'h1);
  wire       eob_w  = last_w & hi_r;
  // Capture two cycles into the high half: the two sync flops make
  // the sampled value the line level just before the rise; needs H>=2
  wire       cap_w  = run_w & hi_r & (hc_r == 3'h1);
  wire       sel_w  = (st_r == ENG_IDLE) ? chan_i : chan_r;
  wire       run_w  = (st_r == ENG_RUN);

  // Launch on the falling half, device samples on the rise
  always_comb begin
    pin_nxt = pin_r;
    if (!run_w) begin
      pin_nxt = '0;
      if (start_i) begin
        pin_nxt = '{mdc: 1'b0, mdo: PREAMBLE[31], oe: 1'b1};
      end
    end else if (last_w) begin
      if (!hi_r) begin
        pin_nxt.mdc = 1'b1;
      end else if (bit_r == LAST_BIT) begin
        pin_nxt = '0;
      end else begin
        pin_nxt.mdc = 1'b0;
        pin_nxt.mdo = sh_r[62];
        pin_nxt.oe  = !(rd_r && bit_r >= TA_BIT - 6'h1);
      end
    end
  end

  // Only the selected channel moves; the other stays released
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_r   <= '0;
      pins0_o <= '0;
      pins1_o <= '0;
    end else begin
      pin_r   <= pin_nxt;
      pins0_o <= sel_w ? '0 : pin_nxt;
      pins1_o <= sel_w ? pin_nxt : '0;
    end
  end

  // ------------------------------------------------------------
  // Frame sequencing and read capture
  // ------------------------------------------------------------
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r    <= ENG_IDLE;
      f_r     <= '0;
      sh_r    <= '0;
      bit_r   <= '0;
      hc_r    <= '0;
      hi_r    <= 1'b0;
      rd_r    <= 1'b0;
      chan_r  <= CHAN_RST;
      opt_r   <= OPT_RST;
      done_o  <= 1'b0;
      rdata_o <= '0;
    end else begin
      done_o <= 1'b0;
      case (st_r)
        ENG_IDLE: if (start_i) begin
          st_r    <= ENG_RUN;
          f_r     <= frame_i;
          sh_r    <= frame_bits(frame_i);
          bit_r   <= '0;
          hc_r    <= '0;
          hi_r    <= 1'b0;
          rd_r    <= is_read(frame_i.op);
          chan_r  <= chan_i;
          opt_r   <= opt_i;
          rdata_o <= '0;
        end
        ENG_RUN: begin
          hc_r <= last_w ? 3'h0 : hc_r + 3'h1;
          if (last_w) hi_r <= !hi_r;
          // Device changes the line just after each rise, so a later
          // sample would pick up the following bit
          if (cap_w && rd_r && bit_r >= DATA_BIT) begin
            rdata_o <= {rdata_o[14:0], mdi_i};
          end
          if (eob_w) begin
            sh_r  <= {sh_r[62:0], 1'b0};
            bit_r <= bit_r + 6'h1;
            if (bit_r == LAST_BIT) begin
              st_r   <= ENG_IDLE;
              done_o <= 1'b1;
            end
          end
        end
        default: st_r <= ENG_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_preamble_ones: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    run_w && bit_r < ST_BIT |-> pin_r.oe && pin_r.mdo)
    else $error("preamble bit not a driven one");

  a_legacy_start: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    run_w && is_legacy(f_r.op) && bit_r[5:1] == ST_BIT[5:1]
    |-> pin_r.mdo == bit_r[0])
    else $error("legacy start field is not 01");

  a_ext_start: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    run_w && !is_legacy(f_r.op) && bit_r[5:1] == ST_BIT[5:1]
    |-> !pin_r.mdo)
    else $error("extended start field is not 00");

  a_read_release: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    run_w && rd_r && bit_r >= TA_BIT |-> !pin_r.oe)
    else $error("line driven during read turnaround or data");

  a_write_ta: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    run_w && !rd_r && bit_r[5:1] == TA_BIT[5:1]
    |-> pin_r.oe && pin_r.mdo == !bit_r[0])
    else $error("write turnaround is not driven 10");

  a_data_msb: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    run_w && !rd_r && bit_r == DATA_BIT |-> pin_r.mdo == f_r.data[15])
    else $error("data field not sent msb first");

  a_mdc_std: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    $rose(pin_r.mdc) && !opt_r |-> pin_r.mdc[*5] ##1 !pin_r.mdc)
    else $error("standard clock high phase wrong");

  a_mdc_opt: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    $rose(pin_r.mdc) && opt_r |-> pin_r.mdc[*3] ##1 !pin_r.mdc)
    else $error("optical module clock high phase wrong");

  a_launch_low: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    run_w && $changed(pin_r.mdo) |-> !pin_r.mdc)
    else $error("data changed while clock high");

  a_other_idle: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    run_w |-> (chan_r ? pins0_o : pins1_o) == '0)
    else $error("unselected channel not idle");

endmodule : mdio_frame_engine

// [rtl/mdio_station_manager.sv]
// Top of the MDIO station manager: APB register file, frame table,
// clock crossing, batch sequencer and the two management channels.
// Assumes an APB master on clk_i and a free running link_clk_i.
`timescale 1ns/1ps

// Summary of operation
// - Manager always sources the management clock; bits are timed on it.
// - Manager launches command bits with the clock; device samples them.
// - Device drives read bits on the clock; manager samples them.
// - Legacy frame: ones, start 01, op 10/01, two addresses, TA, data.
// - Reads release the line in turnaround; writes drive 1 then 0.
// - Extended frame: start 00, ops 00/01/11/10, addresses, TA, field.
// - Legacy frames take two 5-bit addresses, 16-bit data; return 16 bits.
// - Extended frames take port, device address and a 16-bit value.
// - Read and post-read-increment frames return 16 captured bits.
// - Batches of up to 15 independent frames run back to back.
// - A second separately pinned channel is selected by number 1.
// - Optical module flag runs the batch with a 288 ns management clock period.
module mdio_station_manager
  import mdio_mgr_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        link_clk_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             mdc0_o,
  output logic             mdio0_o,
  output logic             mdio0_oe_o,
  input  wire logic        mdio0_i,
  output logic             mdc1_o,
  output logic             second_mgmt_channel_o,
  output logic             second_mgmt_channel_oe_o,
  input  wire logic        second_mgmt_channel_i
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Word slot of an address inside a table
  function automatic logic [3:0] slot(logic [7:0] a,
                                      logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return d[5:2];
  endfunction : slot

  // Address falls in a 15-word table starting at base
  function automatic logic in_table(logic [7:0] a,
                                    logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    return (a >= base) && (d[7:2] < {2'h0, MAX_FRAMES});
  endfunction : in_table

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ISSUE = 2'b01,
    SEQ_WAIT  = 2'b10
  } seq_state_t;

  // Register clock domain state
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        chan_r;
  logic        opt_r;
  logic [3:0]  cnt_r;
  logic        busy_r;
  logic        done_r;
  logic        req_tgl_r;
  logic        dn_s1_r;
  logic        dn_s2_r;
  logic        dn_s3_r;
  frame_t      tab_r [0:14];

  // Link clock domain state
  logic        req_s1_r;
  logic        req_s2_r;
  logic        req_s3_r;
  logic        done_tgl_r;
  logic        m0_s1_r;
  logic        m0_s2_r;
  logic        m1_s1_r;
  logic        m1_s2_r;
  seq_state_t  seq_r;
  logic [3:0]  idx_r;
  logic        eng_start_r;
  logic [15:0] res_mem [0:14];

  // Engine connections
  mdio_pins_t  p0_w;
  mdio_pins_t  p1_w;
  logic        eng_done_w;
  logic [15:0] eng_rdata_w;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire       acc_w      = psel_i & penable_i;
  wire       xfer_w     = acc_w & pready_r;
  wire       wr_w       = xfer_w & pwrite_i;
  wire       algn_w     = (paddr_i[1:0] == 2'h0);
  wire       ctrl_hit_w = algn_w & (paddr_i == CTRL_OFS);
  wire       stat_hit_w = algn_w & (paddr_i == STAT_OFS);
  wire       frm_hit_w  = algn_w & in_table(paddr_i, FRM_BASE);
  wire       res_hit_w  = algn_w & in_table(paddr_i, RES_BASE);
  wire       hit_w      = ctrl_hit_w | stat_hit_w |
                          frm_hit_w | res_hit_w;
  wire [3:0] fidx_w     = slot(paddr_i, FRM_BASE);
  wire [3:0] ridx_w     = slot(paddr_i, RES_BASE);

  // Control write fields; a zero count starts nothing
  wire [3:0] wcnt_w  = pwdata_i[CTRL_CNT_LSB +: 4];
  wire       cfg_w   = wr_w & ctrl_hit_w & !busy_r;
  wire       start_w = cfg_w & pwdata_i[CTRL_START_BIT] &
                       (wcnt_w != CNT_RST);
  wire       tab_w   = wr_w & frm_hit_w & !busy_r;

  // Done toggle arriving from the link side
  wire       done_edge_w = dn_s2_r ^ dn_s3_r;

  // Read selection; table words stay put while a batch runs
  wire [31:0] ctrl_rd_w = {24'h0, cnt_r, 1'b0, opt_r, chan_r, 1'b0};
  wire [31:0] stat_rd_w = {30'h0, done_r, busy_r};
  wire [31:0] frm_rd_w  = {3'h0, tab_r[fidx_w]};
  wire [31:0] res_rd_w  = {16'h0, res_mem[ridx_w]};
  wire [31:0] rd_mux_w  = ctrl_hit_w ? ctrl_rd_w :
                          stat_hit_w ? stat_rd_w :
                          frm_hit_w  ? frm_rd_w  :
                          res_hit_w  ? res_rd_w  : 32'h0;

  // ------------------------------------------------------------
  // APB answer: one wait state, then data and error with pready
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc_w & !pready_r;
      prdata_r  <= (acc_w & !pready_r & !pwrite_i) ? rd_mux_w : '0;
      pslverr_r <= acc_w & !pready_r & !hit_w;
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = pready_r;
  assign pslverr_o = pslverr_r;

  // ------------------------------------------------------------
  // Control and status
  // ------------------------------------------------------------
  // Settings freeze while busy so the link side can read them
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      chan_r <= CHAN_RST;
      opt_r  <= OPT_RST;
      cnt_r  <= CNT_RST;
    end else if (cfg_w) begin
      chan_r <= pwdata_i[CTRL_CHAN_BIT];
      opt_r  <= pwdata_i[CTRL_OPT_BIT];
      cnt_r  <= wcnt_w;
    end
  end

  // Busy from start to the returned done event
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      req_tgl_r <= 1'b0;
    end else begin
      if (start_w) begin
        busy_r    <= 1'b1;
        req_tgl_r <= !req_tgl_r;
      end else if (done_edge_w) begin
        busy_r <= 1'b0;
      end
      // Set wins; both cannot meet since start needs idle
      if (done_edge_w) done_r <= 1'b1;
      else if (start_w) done_r <= 1'b0;
    end
  end

  // Frame table, written only while idle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 15; i++) tab_r[i] <= '0;
    end else if (tab_w) begin
      tab_r[fidx_w] <= pwdata_i[FRM_W-1:0];
    end
  end

  // Done toggle back into the register domain
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dn_s1_r <= 1'b0;
      dn_s2_r <= 1'b0;
      dn_s3_r <= 1'b0;
    end else begin
      dn_s1_r <= done_tgl_r;
      dn_s2_r <= dn_s1_r;
      dn_s3_r <= dn_s2_r;
    end
  end

  // ------------------------------------------------------------
  // Link side crossings
  // ------------------------------------------------------------
  // Request toggle through three flops, both data pins through two each
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_s3_r <= 1'b0;
      m0_s1_r  <= 1'b0;
      m0_s2_r  <= 1'b0;
      m1_s1_r  <= 1'b0;
      m1_s2_r  <= 1'b0;
    end else begin
      req_s1_r <= req_tgl_r;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      m0_s1_r  <= mdio0_i;
      m0_s2_r  <= m0_s1_r;
      m1_s1_r  <= second_mgmt_channel_i;
      m1_s2_r  <= m1_s1_r;
    end
  end

  wire start_edge_w = req_s2_r ^ req_s3_r;
  wire mdi_w        = chan_r ? m1_s2_r : m0_s2_r;
  wire last_idx_w   = (idx_r == cnt_r - 4'h1);

  // ------------------------------------------------------------
  // Batch sequencer: one frame after another
  // ------------------------------------------------------------
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_r       <= SEQ_IDLE;
      idx_r       <= '0;
      eng_start_r <= 1'b0;
      done_tgl_r  <= 1'b0;
    end else begin
      eng_start_r <= 1'b0;
      case (seq_r)
        SEQ_IDLE: if (start_edge_w) begin
          idx_r <= '0;
          seq_r <= SEQ_ISSUE;
        end
        SEQ_ISSUE: begin
          eng_start_r <= 1'b1;
          seq_r       <= SEQ_WAIT;
        end
        SEQ_WAIT: if (eng_done_w) begin
          if (last_idx_w) begin
            done_tgl_r <= !done_tgl_r;
            seq_r      <= SEQ_IDLE;
          end else begin
            idx_r <= idx_r + 4'h1;
            seq_r <= SEQ_ISSUE;
          end
        end
        default: seq_r <= SEQ_IDLE;
      endcase
    end
  end

  // Results per slot; read back once the batch is done
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < 15; i++) res_mem[i] <= '0;
    end else if (seq_r == SEQ_WAIT && eng_done_w) begin
      res_mem[idx_r] <= eng_rdata_w;
    end
  end

  // ------------------------------------------------------------
  // Frame engine and pins
  // ------------------------------------------------------------
  mdio_frame_engine u_engine (
    .link_clk_i (link_clk_i),
    .reset_i    (reset_i),
    .start_i    (eng_start_r),
    .frame_i    (tab_r[idx_r]),
    .chan_i     (chan_r),
    .opt_i      (opt_r),
    .mdi_i      (mdi_w),
    .pins0_o    (p0_w),
    .pins1_o    (p1_w),
    .done_o     (eng_done_w),
    .rdata_o    (eng_rdata_w)
  );

  // Engine pin outputs are flops already
  assign mdc0_o     = p0_w.mdc;
  assign mdio0_o    = p0_w.mdo;
  assign mdio0_oe_o = p0_w.oe;
  assign mdc1_o     = p1_w.mdc;
  assign second_mgmt_channel_o    = p1_w.mdo;
  assign second_mgmt_channel_oe_o = p1_w.oe;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_start_busy: assert property (
    @(posedge clk_i) disable iff (reset_i)
    start_w |=> busy_r && !done_r)
    else $error("start did not raise busy");

  a_batch_kick: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    start_edge_w && seq_r == SEQ_IDLE
    |=> seq_r == SEQ_ISSUE ##1 eng_start_r)
    else $error("batch did not issue its first frame");

  a_batch_limit: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    seq_r != SEQ_IDLE |-> idx_r < cnt_r)
    else $error("frame index passed the batch count");

  a_result_store: assert property (
    @(posedge link_clk_i) disable iff (reset_i)
    seq_r == SEQ_WAIT && eng_done_w
    |=> res_mem[$past(idx_r)] == $past(eng_rdata_w))
    else $error("frame result not stored in its slot");

  a_apb_answer: assert property (
    @(posedge clk_i) disable iff (reset_i)
    acc_w && !pready_r |=> pready_r)
    else $error("apb access not answered next cycle");

endmodule : mdio_station_manager

// [dv/mdio_phy_model.sv]
// Device model of one management channel; logs what it decodes.
// Assumes a pulled-up line and a clock held still between frames.
`timescale 1ns/1ps
module mdio_phy_model (
  input  wire logic mdc_i,
  input  wire logic mdo_i,
  input  wire logic oe_i,
  output logic      line_o
);
  logic [31:0] got [$];  // Driven bits 32..63 of each frame
  logic [15:0] sent [$];  // Answer prepared for each frame
  logic [31:0] sh = 32'h0;
  logic [15:0] ha = 16'h0, rv = 16'h0;
  logic        rd = 1'b0, drv = 1'b0, dq = 1'b0, dv;
  int          ones = 0, pos = 0;
  // Released bits count as 0, so the preamble must be driven
  assign dv = oe_i & mdo_i;
  assign line_o = oe_i ? mdo_i : drv ? dq : 1'b1;
  // Sample at each rise, answer just after it
  always @(posedge mdc_i) begin
    if (pos == 0) begin
      pos = (!dv && ones >= 32) ? 33 : 0;
      ones = dv ? ones + 1 : 0;
    end else begin
      sh = {sh[30:0], dv};
      pos++;
    end
    if (pos == 46)
      {rd, rv} = {sh[11], {sh[9:0], 6'h0} ^ ha};
    if (pos == 64) begin  // Address frames load, post-read bumps
      got.push_back(sh);
      sent.push_back(rv);
      ha = sh[30] ? ha : sh[29:28] == 2'h2 ? ha + 16'h1 :
           sh[29:28] == 2'h0 ? sh[15:0] : ha;
      {pos, ones, rd, sh} = '0;
    end
    // Turnaround 0, then 16 bits msb first
    drv <= rd && pos >= 47;
    dq <= pos == 47 ? 1'b0 : rv[(63 - pos) & 15];
  end
endmodule : mdio_phy_model

// [dv/mdio_station_manager_tb.sv]
// Bench: APB master, two device models, queue model of batches.
// Assumes the package register map and pulled-up data lines.
`timescale 1ns/1ps
module mdio_station_manager_tb
  import mdio_mgr_pkg::*;
;
  localparam logic [1:0] OPC [6] = '{2'h2, 2'h1, 2'h0, 2'h1, 2'h3, 2'h2};
  logic        clk = 1'b0, rst = 1'b1, lclk = 1'b0;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  pa = 8'h0;
  logic [31:0] pwd = 32'h0, seed = 32'h0001_2337;
  logic [31:0] prd, rd, w, g, x;
  logic [31:0] fq [$];
  logic [15:0] e;
  logic        prdy, perr, er, rdf, c0, d0, o0, l0, c1, d1, o1, l1;
  int          n_mismatch = 0, n_checks = 0, n, op, k;
  time         t = 0, p = 1_000_000;
  mdio_station_manager dut (
    .clk_i(clk), .reset_i(rst), .link_clk_i(lclk), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .mdc0_o(c0), .mdio0_o(d0), .mdio0_oe_o(o0), .mdio0_i(l0),
    .mdc1_o(c1), .second_mgmt_channel_o(d1), .second_mgmt_channel_oe_o(o1), .second_mgmt_channel_i(l1)
  );
  mdio_phy_model phy0 (.mdc_i(c0), .mdo_i(d0), .oe_i(o0), .line_o(l0));
  mdio_phy_model phy1 (.mdc_i(c1), .mdo_i(d1), .oe_i(o1), .line_o(l1));
  // 50 ns register clock; 48 ns link clock, offset in phase
  initial forever #25 clk = ~clk;
  initial begin
    #7;
    forever #24 lclk = ~lclk;
  end
  // Shortest management clock period; one channel runs at a time
  always @(posedge (c0 | c1)) begin
    p = ($time - t < p) ? $time - t : p;
    t = $time;
  end
  // Watchdog: both batches need well under a millisecond
  initial begin
    #2_000_000;
    n_mismatch++;
    final_report();
  end
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    pa <= a;
    pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // Xorshift source for addresses and data
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input logic [31:0] s, input logic [31:0] ex);
    n_checks++;
    if (s !== ex) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, ex);
    end
  endtask : chk
  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, FRM_BASE + 8'h3c, 32'h0);
    chk(32'(er), 32'h1);  // No slot past fifteen frames
    // Channel 0 runs every code; channel 1 runs optical timing
    for (int r = 0; r < 2; r++) begin
      n = r ? 3 : 15;
      p = 1_000_000;
      for (int i = 0; i < n; i++) begin
        op = r ? 5 - i : i % 6;
        w = {3'h0, 3'(op), 26'(rnd())};
        fq.push_back(w);
        apb(1'b1, FRM_BASE + 8'(4 * i), w);
      end
      apb(1'b1, CTRL_OFS, {24'h0, 4'(n), 1'b0, 1'(r), 1'(r), 1'b1});
      rd = 32'h0;
      for (k = 0; k < 9000 && rd[1] !== 1'b1; k++)
        apb(1'b0, STAT_OFS, 32'h0);
      chk(rd, 32'h2);  // Whole batch done, busy clear
      x = 2 * LINK_NS * (r ? OPT_HALF_CYC : STD_HALF_CYC);
      chk(32'(p), x);  // Bit period per timing mode
      for (int i = 0; i < n; i++) begin
        w = fq.pop_front();
        op = w[28:26];
        rdf = op == 0 || op > 3;
        e = r ? phy1.sent.pop_front() : phy0.sent.pop_front();
        g = r ? phy1.got.pop_front() : phy0.got.pop_front();
        x = {1'b0, op < 2, OPC[op], w[25:16], !rdf, 1'b0, 16'h0};
        chk(g, rdf ? x : x | w[15:0]);
        apb(1'b0, RES_BASE + 8'(4 * i), 32'h0);
        chk(rd, {16'h0, rdf ? e : 16'h0});
      end
      chk(32'(r ? phy0.got.size() : phy1.got.size()), 32'h0);
      chk(32'(c0 | c1), 32'h0);  // Clocks idle low after a batch
    end
    final_report();
  end
endmodule : mdio_station_manager_tb
